// ### src/port_cfg_pkg.sv
// package: per-port configuration types, defaults and route rewrite constants
// Operation
// R1 - each port holds its own drop address, legal only 0 to 199
// R2 - factory drops for ports 0..4 are 0,1,2,3,4
// R3 - protocol mode select among ten modes, default native routed
// R4 - baud select from fifteen rates, default 9600; port 0 a subset
// R5 - parity even, odd or none, default even
// R6 - seven or eight data bits, default eight
// R7 - one or two stop bits, default one
// R8 - buffer count 2 to 16, default 16
// R9 - checksum block check or crc in listed modes, default block check
// R10 - software sets crc for peripheral network mode
// R11 - drop 205 in route is replaced by appendix, earlier drops kept
// R12 - replacement on: incoming route discarded, appendix used
// R13 - option bit 2 on routed port: 205,X uses table entry X
// R14 - table reply route reversed to X,205
// R15 - table replacement only on single-transaction ports; the code applies it on any routed port with option bit 2 set
// R16 - line driver mode on ports 1..4 in four modes, default point-to-point
// R17 - automatic transfer only in listed modes, with interval and counts
// R18 - register writes take effect at once and are kept
// R19 - out-of-range writes rejected, old value kept
package port_cfg_pkg;
   localparam int NUM_PORTS = 5;
   localparam int ROUTE_LEN = 8;
   localparam logic [7:0] DROP_MAX = 8'hc7;
   localparam logic [7:0] DROP_APPEND = 8'hcd;
   localparam logic [7:0] DROP_NONE = 8'hff;
   localparam int OPT_TABLE_BIT = 2;
   localparam int TABLE_DEPTH = 128;
   localparam logic [4:0] BUF_MIN = 5'h02;
   localparam logic [4:0] BUF_MAX = 5'h10;
   localparam logic [3:0] BAUD_COUNT = 4'hf;
   localparam logic [3:0] BAUD_DEFAULT = 4'hc;
   localparam logic [3:0] BAUD_PORT0_MAX = 4'hc;
   localparam logic [3:0] MODE_COUNT = 4'ha;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [3:0] {
      MODE_ROUTED, MODE_BRIDGE, MODE_PERIPH, MODE_TRANSP, MODE_SHARE,
      MODE_POWER, MODE_GATEWAY, MODE_MULTIDROP, MODE_REGPROTO, MODE_REMOTE
   } mode_type;
   typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} parity_type;
   typedef enum logic [1:0] {DRV_P2P, DRV_4W_SLAVE, DRV_HDX_MASTER, DRV_2W_PEER} driver_type;
   typedef enum logic [3:0] {
      F_DROP, F_MODE, F_BAUD, F_PARITY, F_DATA, F_STOP, F_BUFS, F_CRC, F_APPEND,
      F_REPLACE, F_DRIVER, F_OPTIONS, F_XFER, F_TABLE
   } field_type;

   typedef struct packed {
      logic [7:0] drop;
      mode_type mode;
      logic [3:0] baud;
      parity_type parity;
      logic data7;
      logic stop2;
      logic [4:0] bufs;
      logic crc;
      logic replace;
      driver_type driver;
      logic [7:0] options;
      logic [15:0] xfer_interval;
      logic [7:0] xfer_rd_count;
      logic [7:0] xfer_wr_count;
      logic xfer_on;
      logic [ROUTE_LEN*8-1:0] appendix;
   } port_cfg_type;

   typedef struct packed {
      logic [2:0] port;
      field_type field;
      logic [6:0] index;
      logic [ROUTE_LEN*8-1:0] data;
   } cfg_write_type;

   typedef struct packed {
      logic [2:0] port;
      logic [ROUTE_LEN*8-1:0] route;
   } route_word_type;

   typedef struct packed {
      logic [ROUTE_LEN*8-1:0] route;
      logic [ROUTE_LEN*8-1:0] reply;
      logic table_hit;
   } route_out_type;
endpackage

// ### src/route_fifo.sv
// file: small flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module route_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   // fill side
   input wire logic [WIDTH-1:0] IN_DATA_IN,
   input wire logic IN_VALID_IN,
   output logic IN_READY_OUT,
   // drain side
   output logic [WIDTH-1:0] OUT_DATA_OUT,
   output logic OUT_VALID_OUT,
   input wire logic OUT_READY_IN
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_state_type;
   fifo_state_type st_reg, st_next;
   logic push, pop;

   assign IN_READY_OUT = st_reg.cnt != (AW+1)'(DEPTH);
   assign OUT_VALID_OUT = st_reg.cnt != '0;
   assign OUT_DATA_OUT = st_reg.mem[st_reg.rd];
   assign push = IN_VALID_IN && IN_READY_OUT;
   assign pop = OUT_VALID_OUT && OUT_READY_IN;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = IN_DATA_IN;
         st_next.wr = AW'(st_reg.wr + 1'b1);
      end
      if (pop) begin
         st_next.rd = AW'(st_reg.rd + 1'b1);
      end
      st_next.cnt = (AW+1)'(st_reg.cnt + push - pop);
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// ### src/port_config.sv
// file: five-port configuration store and route rewrite engine
`timescale 1ns/100ps
module port_config (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   // configuration write
   input wire logic CFG_WR_IN,
   input wire port_cfg_pkg::cfg_write_type CFG_WORD_IN,
   output logic CFG_ACK_OUT,
   output logic CFG_REJECT_OUT,
   // per-port settings view
   input wire logic [2:0] VIEW_PORT_IN,
   output port_cfg_pkg::port_cfg_type VIEW_CFG_OUT,
   output logic XFER_ALLOWED_OUT,
   output logic CRC_ALLOWED_OUT,
   // incoming route
   input wire logic ROUTE_VALID_IN,
   input wire port_cfg_pkg::route_word_type ROUTE_IN,
   output logic ROUTE_READY_OUT,
   // rewritten route
   output logic ROUTE_VALID_OUT,
   output port_cfg_pkg::route_out_type ROUTE_OUT,
   input wire logic ROUTE_READY_IN
);
   localparam int RW = port_cfg_pkg::ROUTE_LEN * 8;

   typedef struct packed {
      port_cfg_pkg::port_cfg_type [port_cfg_pkg::NUM_PORTS-1:0] cfg;
      logic [port_cfg_pkg::TABLE_DEPTH-1:0][RW-1:0] slave_table;
      logic ack;
      logic reject;
      logic out_valid;
      port_cfg_pkg::route_out_type out;
   } state_type;
   state_type st_reg, st_next;

   port_cfg_pkg::route_word_type fifo_data;
   logic fifo_valid, fifo_ready;

   // ****************************************
   // helpers
   // ****************************************

   // byte i of a route, drop 0 first in the low byte
   function automatic logic [7:0] drop_at(input logic [RW-1:0] r, input int i);
      drop_at = r[i*8 +: 8];
   endfunction

   function automatic port_cfg_pkg::port_cfg_type cfg_default(input int p);
      port_cfg_pkg::port_cfg_type c;
      c = '0;
      c.drop = 8'(p); // R2
      c.mode = port_cfg_pkg::MODE_ROUTED; // R3
      c.baud = port_cfg_pkg::BAUD_DEFAULT; // R4
      c.parity = port_cfg_pkg::PAR_EVEN; // R5
      c.data7 = 1'b0; // R6
      c.stop2 = 1'b0; // R7
      c.bufs = port_cfg_pkg::BUF_MAX; // R8
      c.crc = 1'b0; // R9
      c.driver = port_cfg_pkg::DRV_P2P; // R16
      c.appendix = {port_cfg_pkg::ROUTE_LEN{port_cfg_pkg::DROP_NONE}};
      cfg_default = c;
   endfunction

   function automatic logic crc_mode(input port_cfg_pkg::mode_type m);
      crc_mode = m inside {port_cfg_pkg::MODE_ROUTED, port_cfg_pkg::MODE_BRIDGE,
         port_cfg_pkg::MODE_POWER, port_cfg_pkg::MODE_MULTIDROP,
         port_cfg_pkg::MODE_PERIPH};
   endfunction

   function automatic logic xfer_mode(input port_cfg_pkg::mode_type m);
      xfer_mode = m inside {port_cfg_pkg::MODE_ROUTED, port_cfg_pkg::MODE_BRIDGE,
         port_cfg_pkg::MODE_POWER, port_cfg_pkg::MODE_REGPROTO,
         port_cfg_pkg::MODE_PERIPH};
   endfunction

   // ****************************************
   // input fifo
   // ****************************************

   route_fifo #(
      .WIDTH($bits(port_cfg_pkg::route_word_type)),
      .DEPTH(port_cfg_pkg::FIFO_DEPTH)
   ) in_fifo (
      .CLK_IN(CLK_IN),
      .SYS_RST_IN(SYS_RST_IN),
      .IN_DATA_IN(ROUTE_IN),
      .IN_VALID_IN(ROUTE_VALID_IN),
      .IN_READY_OUT(ROUTE_READY_OUT),
      .OUT_DATA_OUT(fifo_data),
      .OUT_VALID_OUT(fifo_valid),
      .OUT_READY_IN(fifo_ready)
   );

   // ****************************************
   // outputs
   // ****************************************

   assign fifo_ready = !st_reg.out_valid || ROUTE_READY_IN;
   assign ROUTE_VALID_OUT = st_reg.out_valid;
   assign ROUTE_OUT = st_reg.out;
   assign CFG_ACK_OUT = st_reg.ack;
   assign CFG_REJECT_OUT = st_reg.reject;
   assign VIEW_CFG_OUT = (VIEW_PORT_IN < 3'(port_cfg_pkg::NUM_PORTS)) ?
      st_reg.cfg[VIEW_PORT_IN] : '0;
   assign XFER_ALLOWED_OUT = VIEW_CFG_OUT.xfer_on && xfer_mode(VIEW_CFG_OUT.mode); // R17
   assign CRC_ALLOWED_OUT = crc_mode(VIEW_CFG_OUT.mode); // R9

   // ****************************************
   // next state
   // ****************************************

   always_comb begin
      port_cfg_pkg::port_cfg_type c;
      port_cfg_pkg::cfg_write_type w;
      logic ok;
      logic [RW-1:0] r, app, res;
      int k, j;
      c = '0;
      w = CFG_WORD_IN;
      ok = 1'b0;
      r = '0;
      app = '0;
      res = '0;
      k = 0;
      j = 0;
      st_next = st_reg;
      st_next.ack = 1'b0;
      st_next.reject = 1'b0;
      // configuration write, checked before commit
      if (CFG_WR_IN) begin
         ok = w.port < 3'(port_cfg_pkg::NUM_PORTS);
         if (ok) begin
            c = st_reg.cfg[w.port];
         end
         case (w.field)
            port_cfg_pkg::F_DROP: begin
               ok = ok && w.data[7:0] <= port_cfg_pkg::DROP_MAX; // R1
               c.drop = w.data[7:0];
            end
            port_cfg_pkg::F_MODE: begin
               ok = ok && w.data[3:0] < port_cfg_pkg::MODE_COUNT; // R3
               c.mode = port_cfg_pkg::mode_type'(w.data[3:0]);
            end
            port_cfg_pkg::F_BAUD: begin
               ok = ok && w.data[3:0] < port_cfg_pkg::BAUD_COUNT && (w.port != 3'h0 ||
                  w.data[3:0] <= port_cfg_pkg::BAUD_PORT0_MAX); // R4
               c.baud = w.data[3:0];
            end
            port_cfg_pkg::F_PARITY: begin
               ok = ok && w.data[1:0] <= 2'(port_cfg_pkg::PAR_NONE); // R5
               c.parity = port_cfg_pkg::parity_type'(w.data[1:0]);
            end
            port_cfg_pkg::F_DATA: c.data7 = w.data[0]; // R6
            port_cfg_pkg::F_STOP: c.stop2 = w.data[0]; // R7
            port_cfg_pkg::F_BUFS: begin
               ok = ok && w.data[4:0] >= port_cfg_pkg::BUF_MIN &&
                  w.data[4:0] <= port_cfg_pkg::BUF_MAX && w.data[7:5] == 3'h0; // R8
               c.bufs = w.data[4:0];
            end
            port_cfg_pkg::F_CRC: begin
               ok = ok && (crc_mode(c.mode) || !w.data[0]); // R9
               c.crc = w.data[0];
            end
            port_cfg_pkg::F_APPEND: c.appendix = w.data;
            port_cfg_pkg::F_REPLACE: c.replace = w.data[0];
            port_cfg_pkg::F_DRIVER: begin
               ok = ok && w.port != 3'h0 && c.mode inside {port_cfg_pkg::MODE_PERIPH,
                  port_cfg_pkg::MODE_SHARE, port_cfg_pkg::MODE_MULTIDROP,
                  port_cfg_pkg::MODE_REGPROTO}; // R16
               c.driver = port_cfg_pkg::driver_type'(w.data[1:0]);
            end
            port_cfg_pkg::F_OPTIONS: c.options = w.data[7:0];
            port_cfg_pkg::F_XFER: begin
               ok = ok && (xfer_mode(c.mode) || !w.data[32]); // R17
               c.xfer_interval = w.data[15:0];
               c.xfer_rd_count = w.data[23:16];
               c.xfer_wr_count = w.data[31:24];
               c.xfer_on = w.data[32];
            end
            port_cfg_pkg::F_TABLE: ;
            default: ok = 1'b0;
         endcase
         if (ok && w.field == port_cfg_pkg::F_TABLE) begin
            st_next.slave_table[w.index] = w.data; // R13
         end else if (ok) begin
            st_next.cfg[w.port] = c; // R18
         end
         st_next.ack = ok;
         st_next.reject = !ok; // R19
      end
      // route rewrite stage
      if (fifo_ready) begin
         st_next.out_valid = fifo_valid;
      end
      if (fifo_valid && fifo_ready) begin
         c = st_reg.cfg[(fifo_data.port < 3'(port_cfg_pkg::NUM_PORTS)) ?
            fifo_data.port : 3'h0];
         r = fifo_data.route;
         app = c.appendix;
         res = r;
         st_next.out.table_hit = 1'b0;
         st_next.out.reply = '0;
         if (c.options[port_cfg_pkg::OPT_TABLE_BIT] && c.mode == port_cfg_pkg::MODE_ROUTED
               && drop_at(r, 0) == port_cfg_pkg::DROP_APPEND) begin // R13 R15
            res = st_reg.slave_table[7'(drop_at(r, 1))];
            st_next.out.table_hit = 1'b1;
            st_next.out.reply = {{(port_cfg_pkg::ROUTE_LEN-2){port_cfg_pkg::DROP_NONE}},
               port_cfg_pkg::DROP_APPEND, drop_at(r, 1)}; // R14
         end else if (c.replace) begin
            res = app; // R12
         end else begin
            // find the first 205 and splice the appendix there
            k = port_cfg_pkg::ROUTE_LEN;
            for (int i = port_cfg_pkg::ROUTE_LEN - 1; i >= 0; i--) begin
               if (drop_at(r, i) == port_cfg_pkg::DROP_APPEND) begin
                  k = i;
               end
            end
            if (k < port_cfg_pkg::ROUTE_LEN) begin
               res = {port_cfg_pkg::ROUTE_LEN{port_cfg_pkg::DROP_NONE}};
               for (int i = 0; i < port_cfg_pkg::ROUTE_LEN; i++) begin
                  if (i < k) begin
                     res[i*8 +: 8] = drop_at(r, i); // R11
                  end else begin
                     j = i - k;
                     res[i*8 +: 8] = drop_at(app, j); // R11
                  end
               end
            end
         end
         st_next.out.route = res;
      end
   end

   // ****************************************
   // state register
   // ****************************************

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         for (int p = 0; p < port_cfg_pkg::NUM_PORTS; p++) begin
            st_reg.cfg[p] <= cfg_default(p);
         end
         st_reg.slave_table <= '1;
         st_reg.ack <= 1'b0;
         st_reg.reject <= 1'b0;
         st_reg.out_valid <= 1'b0;
         st_reg.out <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************

   cfg_effect_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R18
      CFG_WR_IN && CFG_WORD_IN.field == port_cfg_pkg::F_DROP && CFG_WORD_IN.port == 3'h3
      && CFG_WORD_IN.data[7:0] <= port_cfg_pkg::DROP_MAX
      |=> st_reg.cfg[3].drop == $past(CFG_WORD_IN.data[7:0]))
      else $error("accepted drop write not visible");
   port_reject_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R19
      CFG_WR_IN && CFG_WORD_IN.port >= 3'(port_cfg_pkg::NUM_PORTS) |=> CFG_REJECT_OUT)
      else $error("write to missing port not rejected");
   answer_once_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R18
      CFG_WR_IN |=> CFG_ACK_OUT ^ CFG_REJECT_OUT)
      else $error("write not answered exactly once");
   mode_legal_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R3
      VIEW_CFG_OUT.mode < port_cfg_pkg::MODE_COUNT)
      else $error("stored mode out of range");
   baud_port0_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R4
      st_reg.cfg[0].baud <= port_cfg_pkg::BAUD_PORT0_MAX)
      else $error("port 0 baud outside its subset");
   drop_legal_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R1
      VIEW_CFG_OUT.drop <= port_cfg_pkg::DROP_MAX)
      else $error("stored drop out of range");
   table_hit_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R13
      fifo_valid && fifo_ready && fifo_data.port == 3'h1 && st_reg.cfg[1].mode ==
      port_cfg_pkg::MODE_ROUTED && st_reg.cfg[1].options[port_cfg_pkg::OPT_TABLE_BIT]
      && fifo_data.route[7:0] == port_cfg_pkg::DROP_APPEND |=> ROUTE_OUT.table_hit
      && ROUTE_OUT.route == $past(st_reg.slave_table[fifo_data.route[14:8]]))
      else $error("table route not used");
   drop_range_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R1
      CFG_WR_IN && CFG_WORD_IN.field == port_cfg_pkg::F_DROP
      && CFG_WORD_IN.data[7:0] > port_cfg_pkg::DROP_MAX |=> CFG_REJECT_OUT)
      else $error("illegal drop not rejected");
   keep_old_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R19
      CFG_REJECT_OUT |-> st_reg.cfg == $past(st_reg.cfg))
      else $error("rejected write changed settings");
   buf_range_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R8
      VIEW_CFG_OUT.bufs == 5'h00 || (VIEW_CFG_OUT.bufs >= port_cfg_pkg::BUF_MIN
      && VIEW_CFG_OUT.bufs <= port_cfg_pkg::BUF_MAX))
      else $error("buffer count out of range");
   route_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R11
      ROUTE_VALID_OUT && !ROUTE_READY_IN |=> ROUTE_VALID_OUT && $stable(ROUTE_OUT))
      else $error("route output dropped under stall");
   replace_out_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R12
      fifo_valid && fifo_ready && fifo_data.port == 3'h0 && st_reg.cfg[0].replace
      && !st_reg.cfg[0].options[port_cfg_pkg::OPT_TABLE_BIT]
      |=> ROUTE_OUT.route == $past(st_reg.cfg[0].appendix))
      else $error("replacement route not used");
   table_reply_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R14
      ROUTE_VALID_OUT && ROUTE_OUT.table_hit |-> ROUTE_OUT.reply[15:8] ==
      port_cfg_pkg::DROP_APPEND)
      else $error("table reply route not reversed");
   reset_drop_a: assert property (@(posedge CLK_IN) // R2
      $past(SYS_RST_IN) && !SYS_RST_IN |-> st_reg.cfg[4].drop == 8'h04)
      else $error("port 4 default drop wrong");
endmodule

// ### verification/route_sink.sv
// route consumer model with stall and slow-ready modes
`timescale 1ns/100ps
module route_sink (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   // route from block
   input wire logic VALID_IN,
   input wire port_cfg_pkg::route_out_type DATA_IN,
   output logic READY_OUT,
   // behaviour control
   input wire logic STALL_IN,
   input wire logic SLOW_IN,
   // observation
   output logic [7:0] COUNT_OUT,
   output port_cfg_pkg::route_out_type LAST_OUT
);
   logic phase_reg;
   assign READY_OUT = !STALL_IN && (!SLOW_IN || phase_reg);
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         phase_reg <= 1'b0;
         COUNT_OUT <= 8'h00;
         LAST_OUT <= '0;
      end else begin
         phase_reg <= !phase_reg;
         if (VALID_IN && READY_OUT) begin
            COUNT_OUT <= COUNT_OUT + 8'h01;
            LAST_OUT <= DATA_IN;
         end
      end
   end
endmodule

// ### verification/port_config_tb_top.sv
// self-checking bench for the port configuration and route rewrite block
`timescale 1ns/100ps
module port_config_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   port_cfg_pkg::cfg_write_type word = '0;
   logic ack, rej, xfer_ok, crc_ok, rin_rdy, rout_vld, rout_rdy;
   logic [2:0] vport = 3'h0;
   port_cfg_pkg::port_cfg_type v;
   logic rin_vld = 1'b0;
   port_cfg_pkg::route_word_type rin = '0;
   port_cfg_pkg::route_out_type rout, last;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic [7:0] cnt;
   int err_count = 0;
   int total_checks = 0;

   port_config dut_u (.CLK_IN(clk), .SYS_RST_IN(rst), .CFG_WR_IN(wr), .CFG_WORD_IN(word),
      .CFG_ACK_OUT(ack), .CFG_REJECT_OUT(rej), .VIEW_PORT_IN(vport), .VIEW_CFG_OUT(v),
      .XFER_ALLOWED_OUT(xfer_ok), .CRC_ALLOWED_OUT(crc_ok), .ROUTE_VALID_IN(rin_vld),
      .ROUTE_IN(rin), .ROUTE_READY_OUT(rin_rdy), .ROUTE_VALID_OUT(rout_vld),
      .ROUTE_OUT(rout), .ROUTE_READY_IN(rout_rdy));
   route_sink sink_u (.CLK_IN(clk), .SYS_RST_IN(rst), .VALID_IN(rout_vld), .DATA_IN(rout),
      .READY_OUT(rout_rdy), .STALL_IN(stall), .SLOW_IN(slow), .COUNT_OUT(cnt),
      .LAST_OUT(last));

   initial begin
      forever #25 clk = !clk;
   end

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic [2:0] p, input port_cfg_pkg::field_type f,
                      input logic [6:0] ix, input logic [63:0] d, input logic acc);
      @(posedge clk);
      #1;
      wr = 1'b1;
      word = '{port: p, field: f, index: ix, data: d};
      @(posedge clk);
      #1;
      wr = 1'b0;
      chk({63'h0, ack}, {63'h0, acc});
      chk({63'h0, rej}, {63'h0, !acc});
   endtask

   task automatic view(input logic [2:0] p);
      vport = p;
      #1;
   endtask

   // sends one route and waits for the sink to take its rewrite
   task automatic rt(input logic [2:0] p, input logic [63:0] r, input logic [63:0] er,
                     input logic [63:0] ep, input logic hit);
      logic [7:0] base;
      int k;
      base = cnt;
      rin_vld = 1'b1;
      rin = '{port: p, route: r};
      for (k = 0; k < 50 && !rin_rdy; k++) begin
         @(posedge clk);
         #1;
      end
      if (!rin_rdy) begin
         err_count++;
         give_verdict();
      end
      @(posedge clk);
      #1;
      rin_vld = 1'b0;
      for (k = 0; k < 50 && cnt == base; k++) begin
         @(posedge clk);
         #1;
      end
      if (cnt == base) begin
         err_count++;
         give_verdict();
      end
      chk(last.route, er);
      chk({63'h0, last.table_hit}, {63'h0, hit});
      if (hit) begin
         chk(last.reply, ep);
      end
   endtask

   task automatic defaults_test();
      for (int i = 0; i < 5; i++) begin
         view(3'(i));
         chk(v.drop, 64'(i));
         chk(v.mode, port_cfg_pkg::MODE_ROUTED);
         chk(v.baud, 64'h0c);
         chk(v.parity, port_cfg_pkg::PAR_EVEN);
         chk({v.data7, v.stop2}, 64'h0);
         chk(v.bufs, 64'h10);
         chk(v.crc, 64'h0);
         chk(v.replace, 64'h0);
         chk(v.driver, port_cfg_pkg::DRV_P2P);
         chk(v.appendix, 64'hffffffffffffffff);
      end
   endtask

   task automatic fields_test();
      cfg(3'h3, port_cfg_pkg::F_DROP, 7'h0, 64'hc7, 1'b1);
      cfg(3'h3, port_cfg_pkg::F_DROP, 7'h0, 64'hc8, 1'b0);
      cfg(3'h5, port_cfg_pkg::F_DROP, 7'h0, 64'h10, 1'b0);
      view(3'h3);
      chk(v.drop, 64'hc7);
      view(3'h4);
      chk(v.drop, 64'h04);
      for (int m = 0; m < 10; m++) begin
         cfg(3'h3, port_cfg_pkg::F_MODE, 7'h0, 64'(m), 1'b1);
      end
      cfg(3'h3, port_cfg_pkg::F_MODE, 7'h0, 64'h0a, 1'b0);
      cfg(3'h3, port_cfg_pkg::F_MODE, 7'h0, 64'h03, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_BAUD, 7'h0, 64'h0e, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_BAUD, 7'h0, 64'h0f, 1'b0);
      cfg(3'h0, port_cfg_pkg::F_BAUD, 7'h0, 64'h0c, 1'b1);
      cfg(3'h0, port_cfg_pkg::F_BAUD, 7'h0, 64'h0d, 1'b0);
      cfg(3'h1, port_cfg_pkg::F_PARITY, 7'h0, 64'h1, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_PARITY, 7'h0, 64'h2, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_PARITY, 7'h0, 64'h3, 1'b0);
      cfg(3'h1, port_cfg_pkg::F_DATA, 7'h0, 64'h1, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_STOP, 7'h0, 64'h1, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_BUFS, 7'h0, 64'h01, 1'b0);
      cfg(3'h1, port_cfg_pkg::F_BUFS, 7'h0, 64'h11, 1'b0);
      cfg(3'h1, port_cfg_pkg::F_BUFS, 7'h0, 64'h02, 1'b1);
      view(3'h1);
      chk({v.baud, v.parity, v.data7, v.stop2, v.bufs}, {4'he, 2'h2, 1'b1, 1'b1, 5'h02});
      view(3'h0);
      chk(v.baud, 64'h0c);
   endtask

   task automatic modes_test();
      cfg(3'h2, port_cfg_pkg::F_CRC, 7'h0, 64'h1, 1'b1);
      cfg(3'h3, port_cfg_pkg::F_CRC, 7'h0, 64'h1, 1'b0);
      view(3'h2);
      chk({v.crc, crc_ok}, 64'h3);
      view(3'h3);
      chk({v.crc, crc_ok}, 64'h0);
      cfg(3'h0, port_cfg_pkg::F_DRIVER, 7'h0, 64'h1, 1'b0);
      cfg(3'h4, port_cfg_pkg::F_MODE, 7'h0, 64'h2, 1'b1);
      cfg(3'h4, port_cfg_pkg::F_DRIVER, 7'h0, 64'h3, 1'b1);
      view(3'h4);
      chk(v.driver, port_cfg_pkg::DRV_2W_PEER);
      cfg(3'h4, port_cfg_pkg::F_CRC, 7'h0, 64'h1, 1'b1);
      view(3'h4);
      chk({v.crc, crc_ok}, 64'h3);
      cfg(3'h2, port_cfg_pkg::F_XFER, 7'h0, {31'h0, 1'b1, 8'h02, 8'h03, 16'h0064}, 1'b1);
      view(3'h2);
      chk({v.xfer_on, v.xfer_wr_count, v.xfer_rd_count, v.xfer_interval, xfer_ok},
         {1'b1, 8'h02, 8'h03, 16'h64, 1'b1});
      cfg(3'h3, port_cfg_pkg::F_XFER, 7'h0, {31'h0, 1'b1, 32'h00000001}, 1'b0);
   endtask

   task automatic rewrite_test();
      cfg(3'h0, port_cfg_pkg::F_APPEND, 7'h0, {40'hffffffffff, 24'h011210}, 1'b1);
      rt(3'h0, {48'hffffffffffff, 16'hcd65}, {32'hffffffff, 32'h01121065}, '0, 1'b0);
      cfg(3'h0, port_cfg_pkg::F_REPLACE, 7'h0, 64'h1, 1'b1);
      rt(3'h0, {48'hffffffffffff, 16'h0403}, {40'hffffffffff, 24'h011210}, '0, 1'b0);
      cfg(3'h1, port_cfg_pkg::F_OPTIONS, 7'h0, 64'h04, 1'b1);
      cfg(3'h1, port_cfg_pkg::F_TABLE, 7'h05, {32'hffffffff, 32'h09080706}, 1'b1);
      // one route outstanding at a time on the table port
      rt(3'h1, {48'hffffffffffff, 16'h05cd}, {32'hffffffff, 32'h09080706},
         {48'hffffffffffff, 16'hcd05}, 1'b1);
   endtask

   task automatic fifo_test();
      int n;
      int k;
      n = 0;
      stall = 1'b1;
      rin_vld = 1'b1;
      for (int i = 0; i < 8 && rin_rdy; i++) begin
         rin = '{port: 3'h2, route: {56'hffffffffffffff, 8'(i)}};
         @(posedge clk);
         #1;
         n++;
      end
      rin_vld = 1'b0;
      chk(64'(n), 64'(port_cfg_pkg::FIFO_DEPTH + 1));
      stall = 1'b0;
      slow = 1'b1;
      for (int i = 0; i < n; i++) begin
         for (k = 0; k < 50 && cnt == 8'(i + 3); k++) begin
            @(posedge clk);
            #1;
         end
         if (cnt == 8'(i + 3)) begin
            err_count++;
            give_verdict();
         end
         chk(last.route, {56'hffffffffffffff, 8'(i)});
      end
      slow = 1'b0;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      defaults_test();
      fields_test();
      modes_test();
      rewrite_test();
      fifo_test();
      give_verdict();
   end
endmodule
